// [design/lcdm_pkg.sv]
// Purpose: shared constants and types of the lcd multiplex drive core
// Assumes: 250 MHz system clock, AXI4-Lite register access
// Notes: output levels are 2-bit codes of the bias ladder taps
package lcdm_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned OSC_NOM_HZ = 64_000;
    localparam int unsigned OSC_DIV = CLK_HZ / OSC_NOM_HZ;
    localparam int unsigned FRAME_DIV = 24;
    localparam logic [4:0] FRAME_LAST = 5'(FRAME_DIV - 1);
    // last count of one backplane slot, indexed by drive mode
    localparam logic [3:0][4:0] SLOT_LAST = {
        5'(FRAME_DIV / 4 - 1),
        5'(FRAME_DIV / 3 - 1),
        5'(FRAME_DIV / 2 - 1),
        5'(FRAME_DIV - 1)
    };

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int unsigned NUM_SEG = 32;
    localparam int unsigned NUM_BP = 4;
    localparam int unsigned PTR_W = 5;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [1:0] {
        MODE_STATIC,
        MODE_MUX2,
        MODE_MUX3,
        MODE_MUX4
    } lcdm_mode_e;

    // ----------------------------------------------------------------
    // drive level codes
    // ----------------------------------------------------------------
    localparam logic [1:0] LVL_VSS = 2'h0;
    localparam logic [1:0] LVL_LOW = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_LCD_SUPPLY_LEVEL = 2'h3;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int unsigned AXI_AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_PTR = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [7:0] REG_RAM = 8'h10;
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_HALF_BIT = 2;
    localparam int unsigned CTRL_EN_BIT = 3;
    localparam lcdm_mode_e CTRL_MODE_RST = MODE_MUX4;
    localparam logic CTRL_HALF_RST = 1'b0;
    localparam logic CTRL_EN_RST = 1'b0;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_SLOT_LSB = 1;
    localparam int unsigned STAT_PHASE_BIT = 3;
    localparam int unsigned STAT_EXT_BIT = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_AW-1:0] araddr;
        logic rready;
    } lcdm_axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lcdm_axil_rsp_s;

    typedef struct packed {
        logic [NUM_BP-1:0][1:0] bp;
        logic [NUM_SEG-1:0][1:0] seg;
    } lcdm_drive_s;

    typedef struct packed {
        logic [1:0] ext_sync;
        logic ext_prev;
        logic [1:0] osc_sync;
        lcdm_mode_e mode;
        logic half;
        logic disp_en;
        logic [PTR_W-1:0] ptr;
        logic [1:0] bidx;
        logic [7:0] shift;
        logic [3:0] nbits;
        logic [NUM_SEG-1:0][3:0] ram;
        logic [NUM_SEG-1:0] latch;
        logic [1:0] slot;
        logic [4:0] scnt;
        logic phase;
        logic aw_got;
        logic [AXI_AW-1:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        lcdm_axil_rsp_s rsp;
        lcdm_drive_s drv;
    } lcdm_core_s;

endpackage

// [design/lcdm_div.sv]
// Purpose: enable-driven modulo counter giving a one-cycle tick
// Assumes: i_last is held steady while counting
// Notes: the tick is combinational so it aligns with the enable
`timescale 1ns/10ps
`default_nettype none

module lcdm_div #(
    parameter int unsigned W = 12
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_en,
    input wire logic i_clr,
    input wire logic [W-1:0] i_last,
    output logic o_tick
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } lcdm_div_st_s;

    lcdm_div_st_s s_reg;
    lcdm_div_st_s s_next;

    assign o_tick = i_en & ~i_clr & (s_reg.cnt == i_last);

    always_comb begin
        s_next = s_reg;
        if (i_clr) begin
            s_next.cnt = '0;
        end else if (o_tick) begin
            s_next.cnt = '0;
        end else if (i_en) begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule

`default_nettype wire

// [design/lcdm_core.sv]
// Purpose: lcd multiplex drive core with display ram and AXI4-Lite regs
// Assumes: single 250 MHz clock, asynchronous active-low reset
// Notes: ext clock and oscillator select pins pass two flops first
//
// Behaviour
// - reset: outputs at supply level, display off
// - reset mode: 1:4, third bias
// - 1:2 takes half or third bias
// - levels follow last written drive mode
// - modes: static, 1:2, 1:3, 1:4
// - 1:3 and 1:4 may use half bias
// - select pin high: external clock; low: internal
// - frame rate is selected clock over 24
// - a latch holds segment data; one latch bit per segment
// - 32 segments follow phase and latch bits
// - spare backplanes mirror used ones by mode
// - ram is 32 words of 4 bits; 1 means segment on
// - bit column n is shown against backplane n
// - display bits stored on arrival, grouped by mode
// - static: byte goes to bit 0 of eight addresses
// - 1:2: byte fills bits 0 and 1 of four addresses
// - 1:3: bits 0 to 2 of three addresses, last bit 2 kept
// - 1:4: byte fills bits 0 to 3 of two addresses
`timescale 1ns/10ps
`default_nettype none

module lcdm_core #(
    parameter int unsigned OSC_DIV = lcdm_pkg::OSC_DIV
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_oscillator_select_pin,
    input wire logic i_ext_clk,
    input wire lcdm_pkg::lcdm_axil_req_s i_axi,
    output lcdm_pkg::lcdm_axil_rsp_s o_axi,
    output logic [1:0] o_backplane_out_0,
    output logic [1:0] o_backplane_out_1,
    output logic [1:0] o_backplane_out_2,
    output logic [1:0] o_backplane_out_3,
    output logic [2*lcdm_pkg::NUM_SEG-1:0] o_segment_outputs
);

    localparam int unsigned OSC_W = $clog2(OSC_DIV + 1);

    lcdm_pkg::lcdm_core_s s_reg;
    lcdm_pkg::lcdm_core_s s_next;

    logic osc_tick;
    logic sel_tick;
    logic frame_end;
    logic wr_fire;
    logic ctrl_wr;

    // ----------------------------------------------------------------
    // level helpers
    // ----------------------------------------------------------------
    // logical backplane that a physical output carries
    function automatic logic [1:0] bp_map(input lcdm_pkg::lcdm_mode_e m,
                                          input logic [1:0] idx);
        logic [1:0] r;
        r = idx;
        case (m)
            lcdm_pkg::MODE_STATIC: r = 2'h0;
            lcdm_pkg::MODE_MUX2: r = {1'b0, idx[0]};
            lcdm_pkg::MODE_MUX3: r = (idx == 2'h3) ? 2'h1 : idx;
            default: r = idx;
        endcase
        return r;
    endfunction

    function automatic logic [1:0] bp_level(input logic active,
                                            input logic ph,
                                            input logic half);
        logic [1:0] r;
        r = lcdm_pkg::LVL_LCD_SUPPLY_LEVEL;
        if (active) begin
            r = ph ? lcdm_pkg::LVL_VSS : lcdm_pkg::LVL_LCD_SUPPLY_LEVEL;
        end else if (half) begin
            r = lcdm_pkg::LVL_LOW;
        end else begin
            r = ph ? lcdm_pkg::LVL_HIGH : lcdm_pkg::LVL_LOW;
        end
        return r;
    endfunction

    function automatic logic [1:0] seg_level(input logic on,
                                             input logic ph,
                                             input logic two_lvl);
        logic [1:0] r;
        r = lcdm_pkg::LVL_LCD_SUPPLY_LEVEL;
        if (on) begin
            r = ph ? lcdm_pkg::LVL_LCD_SUPPLY_LEVEL : lcdm_pkg::LVL_VSS;
        end else if (two_lvl) begin
            r = ph ? lcdm_pkg::LVL_VSS : lcdm_pkg::LVL_LCD_SUPPLY_LEVEL;
        end else begin
            r = ph ? lcdm_pkg::LVL_LOW : lcdm_pkg::LVL_HIGH;
        end
        return r;
    endfunction

    // one ram bit column as a latch image
    function automatic logic [lcdm_pkg::NUM_SEG-1:0] ram_col(
            input logic [lcdm_pkg::NUM_SEG-1:0][3:0] ram,
            input logic [1:0] col);
        logic [lcdm_pkg::NUM_SEG-1:0] r;
        r = '0;
        for (int j = 0; j < lcdm_pkg::NUM_SEG; j++) begin
            r[j] = ram[j][col];
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // clock selection and frame timing
    // ----------------------------------------------------------------
    lcdm_div #(
        .W(OSC_W)
    ) u_osc (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_en(1'b1),
        .i_clr(1'b0),
        .i_last(OSC_W'(OSC_DIV - 1)),
        .o_tick(osc_tick)
    );

    // pin clock edge or internal oscillator tick
    assign sel_tick = s_reg.osc_sync[1] ?
        (s_reg.ext_sync[1] & ~s_reg.ext_prev) : osc_tick;

    lcdm_div #(
        .W(5)
    ) u_frame (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_en(sel_tick),
        .i_clr(ctrl_wr),
        .i_last(lcdm_pkg::FRAME_LAST),
        .o_tick(frame_end)
    );

    // ----------------------------------------------------------------
    // register write decode
    // ----------------------------------------------------------------
    assign wr_fire = s_reg.aw_got & s_reg.w_got & ~s_reg.rsp.bvalid &
                     (s_reg.nbits == '0);
    assign ctrl_wr = wr_fire & s_reg.wstrb[0] &
                     (s_reg.awaddr == lcdm_pkg::REG_CTRL);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [1:0] next_slot;
        logic two_lvl;
        next_slot = '0;
        two_lvl = 1'b0;
        s_next = s_reg;

        // pin synchronisers
        s_next.ext_sync = {s_reg.ext_sync[0], i_ext_clk};
        s_next.ext_prev = s_reg.ext_sync[1];
        s_next.osc_sync = {s_reg.osc_sync[0], i_oscillator_select_pin};

        // slot sequencing, one slot per backplane in use
        next_slot = s_reg.slot + 2'h1;
        if (ctrl_wr) begin
            s_next.slot = '0;
            s_next.latch = ram_col(s_reg.ram, 2'h0);
            s_next.scnt = '0;
            s_next.phase = 1'b0;
        end else if (sel_tick) begin
            if (frame_end) begin
                s_next.slot = '0;
                s_next.scnt = '0;
                s_next.phase = ~s_reg.phase;
                s_next.latch = ram_col(s_reg.ram, 2'h0);
            end else if (s_reg.scnt == lcdm_pkg::SLOT_LAST[s_reg.mode]) begin
                s_next.scnt = '0;
                s_next.slot = next_slot;
                s_next.latch = ram_col(s_reg.ram, next_slot);
            end else begin
                s_next.scnt = s_reg.scnt + 5'h01;
            end
        end

        // serial store of display bits, one bit a cycle, msb first
        if (s_reg.nbits != '0) begin
            s_next.ram[s_reg.ptr][s_reg.bidx] = s_reg.shift[7];
            s_next.shift = {s_reg.shift[6:0], 1'b0};
            s_next.nbits = s_reg.nbits - 4'h1;
            // group width is mode+1 bits; a short last group
            // leaves its upper bits untouched
            if (s_reg.bidx == 2'(s_reg.mode) ||
                    s_reg.nbits == 4'h1) begin
                s_next.bidx = '0;
                s_next.ptr = s_reg.ptr + 5'h01;
            end else begin
                s_next.bidx = s_reg.bidx + 2'h1;
            end
        end

        // AXI write address and data capture
        if (i_axi.awvalid && s_reg.rsp.awready) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = i_axi.awaddr;
            s_next.rsp.awready = 1'b0;
        end
        if (i_axi.wvalid && s_reg.rsp.wready) begin
            s_next.w_got = 1'b1;
            s_next.wdata = i_axi.wdata;
            s_next.wstrb = i_axi.wstrb;
            s_next.rsp.wready = 1'b0;
        end

        // write response completes; reopen both channels
        if (s_reg.rsp.bvalid && i_axi.bready) begin
            s_next.rsp.bvalid = 1'b0;
            s_next.rsp.awready = 1'b1;
            s_next.rsp.wready = 1'b1;
        end

        // register write, held off while a byte is still being stored
        if (wr_fire) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.rsp.bvalid = 1'b1;
            s_next.rsp.bresp = lcdm_pkg::RESP_OKAY;
            case (s_reg.awaddr)
                lcdm_pkg::REG_CTRL: begin
                    if (s_reg.wstrb[0]) begin
                        s_next.mode = lcdm_pkg::lcdm_mode_e'(
                            s_reg.wdata[lcdm_pkg::CTRL_MODE_LSB +: 2]);
                        s_next.half =
                            s_reg.wdata[lcdm_pkg::CTRL_HALF_BIT];
                        s_next.disp_en = s_reg.wdata[lcdm_pkg::CTRL_EN_BIT];
                    end
                end
                lcdm_pkg::REG_DATA: begin
                    if (s_reg.wstrb[0]) begin
                        s_next.shift = s_reg.wdata[7:0];
                        s_next.nbits = lcdm_pkg::BYTE_BITS;
                        s_next.bidx = '0;
                    end
                end
                lcdm_pkg::REG_PTR: begin
                    if (s_reg.wstrb[0]) begin
                        s_next.ptr = s_reg.wdata[lcdm_pkg::PTR_W-1:0];
                        s_next.bidx = '0;
                    end
                end
                lcdm_pkg::REG_STAT, lcdm_pkg::REG_RAM: begin
                    s_next.rsp.bresp = lcdm_pkg::RESP_OKAY;
                end
                default: begin
                    s_next.rsp.bresp = lcdm_pkg::RESP_SLVERR;
                end
            endcase
        end

        // read channel
        if (s_reg.rsp.rvalid && i_axi.rready) begin
            s_next.rsp.rvalid = 1'b0;
            s_next.rsp.arready = 1'b1;
        end
        if (i_axi.arvalid && s_reg.rsp.arready) begin
            s_next.rsp.arready = 1'b0;
            s_next.rsp.rvalid = 1'b1;
            s_next.rsp.rdata = '0;
            s_next.rsp.rresp = lcdm_pkg::RESP_OKAY;
            case (i_axi.araddr)
                lcdm_pkg::REG_CTRL: begin
                    s_next.rsp.rdata[lcdm_pkg::CTRL_MODE_LSB +: 2] = s_reg.mode;
                    s_next.rsp.rdata[lcdm_pkg::CTRL_HALF_BIT] = s_reg.half;
                    s_next.rsp.rdata[lcdm_pkg::CTRL_EN_BIT] = s_reg.disp_en;
                end
                lcdm_pkg::REG_DATA: begin
                    s_next.rsp.rdata = '0;
                end
                lcdm_pkg::REG_PTR: begin
                    s_next.rsp.rdata[lcdm_pkg::PTR_W-1:0] = s_reg.ptr;
                end
                lcdm_pkg::REG_STAT: begin
                    s_next.rsp.rdata[lcdm_pkg::STAT_BUSY_BIT] =
                        (s_reg.nbits != '0);
                    s_next.rsp.rdata[lcdm_pkg::STAT_SLOT_LSB +: 2] = s_reg.slot;
                    s_next.rsp.rdata[lcdm_pkg::STAT_PHASE_BIT] = s_reg.phase;
                    s_next.rsp.rdata[lcdm_pkg::STAT_EXT_BIT] =
                        s_reg.osc_sync[1];
                end
                lcdm_pkg::REG_RAM: begin
                    s_next.rsp.rdata[3:0] = s_reg.ram[s_reg.ptr];
                end
                default: begin
                    s_next.rsp.rresp = lcdm_pkg::RESP_SLVERR;
                end
            endcase
        end

        // drive levels; segments use only the outer levels in static and half bias
        two_lvl = s_reg.half || (s_reg.mode == lcdm_pkg::MODE_STATIC);
        for (int i = 0; i < lcdm_pkg::NUM_BP; i++) begin
            if (s_reg.disp_en) begin
                s_next.drv.bp[i] = bp_level(
                    (s_reg.mode == lcdm_pkg::MODE_STATIC) ||
                    (bp_map(s_reg.mode, 2'(i)) == s_reg.slot),
                    s_reg.phase, s_reg.half);
            end else begin
                s_next.drv.bp[i] = lcdm_pkg::LVL_LCD_SUPPLY_LEVEL;
            end
        end
        for (int j = 0; j < lcdm_pkg::NUM_SEG; j++) begin
            if (s_reg.disp_en) begin
                s_next.drv.seg[j] = seg_level(s_reg.latch[j], s_reg.phase,
                                              two_lvl);
            end else begin
                s_next.drv.seg[j] = lcdm_pkg::LVL_LCD_SUPPLY_LEVEL;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= '0;
            s_reg.mode <= lcdm_pkg::CTRL_MODE_RST;
            s_reg.half <= lcdm_pkg::CTRL_HALF_RST;
            s_reg.disp_en <= lcdm_pkg::CTRL_EN_RST;
            s_reg.rsp.awready <= 1'b1;
            s_reg.rsp.wready <= 1'b1;
            s_reg.rsp.arready <= 1'b1;
            s_reg.drv.bp <= {lcdm_pkg::NUM_BP{lcdm_pkg::LVL_LCD_SUPPLY_LEVEL}};
            s_reg.drv.seg <= {lcdm_pkg::NUM_SEG{lcdm_pkg::LVL_LCD_SUPPLY_LEVEL}};
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_axi = s_reg.rsp;
    assign o_backplane_out_0 = s_reg.drv.bp[0];
    assign o_backplane_out_1 = s_reg.drv.bp[1];
    assign o_backplane_out_2 = s_reg.drv.bp[2];
    assign o_backplane_out_3 = s_reg.drv.bp[3];
    assign o_segment_outputs = s_reg.drv.seg;

endmodule

`default_nettype wire

// [testbench/lcdm_core_monitor.sv]
// Purpose: port checker for lcdm_core
// Assumes: config tracked from bus writes
// Notes: mode checks wait until no write is in flight
`timescale 1ns/10ps
`default_nettype none
module lcdm_core_monitor (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire lcdm_pkg::lcdm_axil_req_s i_axi,
    input wire lcdm_pkg::lcdm_axil_rsp_s o_axi,
    input wire logic [1:0] o_backplane_out_0,
    input wire logic [1:0] o_backplane_out_1,
    input wire logic [1:0] o_backplane_out_2,
    input wire logic [1:0] o_backplane_out_3,
    input wire logic [2*lcdm_pkg::NUM_SEG-1:0] o_segment_outputs
);
    logic [7:0] a_reg;
    logic [4:0] w_reg;
    logic [3:0] c_reg;
    logic q_reg;
    logic ok;
    logic [3:0][1:0] bp;
    logic [3:0] act;
    logic [2:0] on;
    always_comb begin
        bp = {o_backplane_out_3, o_backplane_out_2, o_backplane_out_1,
              o_backplane_out_0};
        for (int i = 0; i < 4; i++) act[i] = bp[i][0] == bp[i][1];
        ok = o_axi.awready && q_reg;
        on = {ok && c_reg[3], c_reg[1:0]};
    end
    // drive config shadow, set on write response
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            a_reg <= 8'h00;
            w_reg <= 5'h00;
            c_reg <= 4'h3;
            q_reg <= 1'b1;
        end else begin
            if (i_axi.awvalid && o_axi.awready) a_reg <= i_axi.awaddr;
            if (i_axi.wvalid && o_axi.wready)
                w_reg <= {i_axi.wstrb[0], i_axi.wdata[3:0]};
            if (o_axi.bvalid && i_axi.bready && a_reg == 8'h00 && w_reg[4])
                c_reg <= w_reg[3:0];
            q_reg <= o_axi.awready;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_dis;
        ok && !c_reg[3] |-> bp == 8'hff && &o_segment_outputs;
    endproperty
    a_dis: assert property (p_dis) else $error("outputs not at supply");
    property p_stat;
        ok && c_reg == 4'h8 |-> bp[1] == bp[0] && bp[2] == bp[0] && bp[3] == bp[0];
    endproperty
    a_stat: assert property (p_stat) else $error("static bp differ");
    property p_mux2;
        on == 3'h5 |-> bp[2] == bp[0] && bp[3] == bp[1];
    endproperty
    a_mux2: assert property (p_mux2) else $error("1:2 bp mirror");
    property p_mux3;
        on == 3'h6 |-> bp[3] == bp[1];
    endproperty
    a_mux3: assert property (p_mux3) else $error("1:3 bp mirror");
    property p_one;
        on == 3'h7 |-> $countones(act) == 1;
    endproperty
    a_one: assert property (p_one) else $error("not one active bp");
    property p_order;
        on == 3'h7 && $past(on) == 3'h7 && act != $past(act)
            |-> act == {$past(act[2:0]), $past(act[3])};
    endproperty
    a_order: assert property (p_order) else $error("bp order");
    property p_half;
        on[2] && c_reg[2] && on[1:0] != 2'h0
            |-> !(bp[0] == 2'h2 || bp[1] == 2'h2 || bp[2] == 2'h2 || bp[3] == 2'h2);
    endproperty
    a_half: assert property (p_half) else $error("half bias level");
    property p_two;
        on[2] && (c_reg[2] || on[1:0] == 2'h0) |->
            ((o_segment_outputs ^ (o_segment_outputs >> 1)) & {32{2'h1}}) == '0;
    endproperty
    a_two: assert property (p_two) else $error("segment mid level");
    property p_resp;
        $fell(o_axi.awready) |-> ##[1:12] o_axi.bvalid;
    endproperty
    a_resp: assert property (p_resp) else $error("write unanswered");
endmodule
bind lcdm_core lcdm_core_monitor u_mon (.i_clk, .i_rst_n, .i_axi, .o_axi,
    .o_backplane_out_0, .o_backplane_out_1, .o_backplane_out_2,
    .o_backplane_out_3, .o_segment_outputs);
`default_nettype wire

// [testbench/lcdm_panel.sv]
// Purpose: passive lcd panel seen through its pixels
// Assumes: level codes 0 and 3 are the supply rails
// Notes: a pixel latches lit under full voltage
`timescale 1ns/10ps
`default_nettype none
module lcdm_panel (
    input wire logic i_clk,
    input wire logic i_clr,
    input wire logic [3:0][1:0] i_bp,
    input wire logic [63:0] i_seg,
    output logic [3:0][31:0] o_lit
);
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 32; j++) begin
                if (i_clr) begin
                    o_lit[i][j] <= 1'b0;
                end else if (i_bp[i][0] == i_bp[i][1] &&
                             (i_bp[i] ^ i_seg[2*j+:2]) == 2'h3) begin
                    o_lit[i][j] <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/tb_lcdm_core.sv]
// Purpose: self-checking bench for lcdm_core
// Assumes: OSC_DIV of 4, bready and rready held high
// Notes: display ram contents are tracked in a bench model
`timescale 1ns/10ps
`default_nettype none
module tb_lcdm_core;
    localparam int DIV = 4;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic osc_sel = 1'b0;
    logic ext_clk = 1'b0;
    logic clr = 1'b0;
    logic [1:0] ecnt = 2'h0;
    lcdm_pkg::lcdm_axil_req_s req = '0;
    lcdm_pkg::lcdm_axil_rsp_s rsp;
    logic [1:0] bp0, bp1, bp2, bp3;
    logic [63:0] seg;
    logic [3:0][31:0] lit;
    logic [31:0] rq[$];
    logic [1:0] bq[$];
    logic [3:0] ram[32];
    logic [4:0] ptr = 5'h00;
    logic [7:0] rnd = 8'h0a;
    logic [31:0] row;
    int errors = 0;
    int cmp_count = 0;
    always #2 i_clk = ~i_clk;
    // external lcd clock, period six cycles
    always @(posedge i_clk) begin
        ecnt <= (ecnt == 2'h2) ? 2'h0 : ecnt + 2'h1;
        if (ecnt == 2'h2) ext_clk <= ~ext_clk;
    end
    lcdm_core #(.OSC_DIV(DIV)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_oscillator_select_pin(osc_sel), .i_ext_clk(ext_clk),
        .i_axi(req), .o_axi(rsp), .o_backplane_out_0(bp0),
        .o_backplane_out_1(bp1), .o_backplane_out_2(bp2),
        .o_backplane_out_3(bp3), .o_segment_outputs(seg));
    lcdm_panel u_panel (.i_clk(i_clk), .i_clr(clr),
        .i_bp({bp3, bp2, bp1, bp0}), .i_seg(seg), .o_lit(lit));
    function logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task results;
        $display("compares=%0d errors=%0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] r = lcdm_pkg::RESP_OKAY);
        bq.push_back(r);
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.awaddr <= a;
        req.wdata <= d;
        do begin
            @(posedge i_clk);
            if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        do begin
            @(posedge i_clk);
            if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
    endtask
    task setp(input logic [4:0] a);
        wr(lcdm_pkg::REG_PTR, {27'h0, a});
        ptr = a;
    endtask
    task put(input logic [1:0] m, input logic [7:0] b);
        int g;
        g = m + 1;
        for (int k = 0; k < 8; k++) begin
            if (k > 0 && k % g == 0) ptr++;
            ram[ptr][k % g] = b[7-k];
        end
        ptr++;
        wr(lcdm_pkg::REG_DATA, {24'h0, b});
    endtask
    task frame(input int e);
        int n;
        logic [1:0] b;
        repeat (2) begin
            n = 0;
            b = bp0;
            while (bp0 === b && n < 999) begin
                @(posedge i_clk);
                n++;
            end
        end
        chk(n, e);
    endtask
    // result checker
    always @(posedge i_clk) begin
        if (i_rst_n && rsp.rvalid === 1'b1) chk(rsp.rdata, rq.pop_front());
        if (i_rst_n && rsp.bvalid === 1'b1) chk(32'(rsp.bresp), bq.pop_front());
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        results();
    end
    initial begin
        req.bready = 1'b1;
        req.rready = 1'b1;
        ram = '{default: 4'h0};
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (8) @(posedge i_clk); // settle, scaled
        chk({bp3, bp2, bp1, bp0}, 32'hff);
        rd(lcdm_pkg::REG_CTRL, 32'h3);
        wr(8'h20, 32'h0, lcdm_pkg::RESP_SLVERR);
        setp(5'd16);
        put(2'h3, 8'hff);
        put(2'h3, 8'hff);
        for (int m = 0; m < 4; m++) begin
            wr(lcdm_pkg::REG_CTRL, 32'(m));
            setp(5'(m * 8));
            rnd = lfsr(rnd);
            put(2'(m), rnd);
            rnd = lfsr(rnd);
            put(2'(m), rnd);
        end
        for (int i = 0; i < 32; i++) begin
            setp(5'(i));
            rd(lcdm_pkg::REG_RAM, {28'h0, ram[i]});
        end
        wr(lcdm_pkg::REG_CTRL, 32'hb);
        clr <= 1'b1;
        @(posedge i_clk);
        clr <= 1'b0;
        repeat (300) @(posedge i_clk);
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 32; j++) row[j] = ram[j][i];
            chk(lit[i], row);
        end
        for (int i = 0; i < 4; i++) begin
            row = 32'(16'hed9a >> 4 * (3 - i)) & 32'hf;
            wr(lcdm_pkg::REG_CTRL, row);
            repeat (200) @(posedge i_clk);
        end
        wr(lcdm_pkg::REG_CTRL, 32'h8);
        frame(24 * DIV);
        osc_sel <= 1'b1;
        repeat (4) @(posedge i_clk);
        frame(24 * 6);
        wr(lcdm_pkg::REG_CTRL, 32'h0);
        repeat (20) @(posedge i_clk);
        chk({bp3, bp2, bp1, bp0}, 32'hff);
        results();
    end
endmodule
`default_nettype wire
